// [pkg/ccdc_pkg.sv]
// Types of the caption decoder control and timing block.
// Assumes nothing beyond the constants header.
package ccdc_pkg;

  // ----------------------------------------------------------------------
  // Pin groups and serial link states
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic interface_style_select;
    logic decoder_power_or_serial_enable;
    logic channel_type_or_serial_data;
    logic language_select_or_serial_clock;
    logic master_reset_n;
    logic horizontal_timing_in;
    logic composite_sync_in;
    logic line21_data_in;
  } ccdc_pins_t;

  typedef struct packed {
    logic       box;
    logic       char_luma_out;
    logic [2:0] rgb;
  } ccdc_video_t;

  typedef enum logic [1:0] {
    CCDC_SER_IDLE  = 2'b00,
    CCDC_SER_SHIFT = 2'b01,
    CCDC_SER_EXEC  = 2'b11
  } ccdc_ser_state_t;

endpackage

// [pkg/ccdc_regs.svh]
// Constants of the caption decoder control and timing block.
// Assumes a 100 MHz system clock; included by the top and the bench.
`ifndef CCDC_REGS_SVH
`define CCDC_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------
`define CCDC_OFF_CTRL       8'h00
`define CCDC_OFF_BOX_DLY    8'h04
`define CCDC_OFF_STATUS     8'h08
`define CCDC_OFF_LAST_CMD   8'h0C
`define CCDC_CTRL_EDS_BIT   0
`define CCDC_CTRL_RGB_LSB   1
`define CCDC_CTRL_CPR_BIT   4
`define CCDC_CTRL_RST       3'h7

// ----------------------------------------------------------------------
// Serial commands
// ----------------------------------------------------------------------
`define CCDC_CMD_FULL_RST   8'h01
`define CCDC_CMD_CP_RST     8'h02
`define CCDC_CMD_SET_PFX    5'h10

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CCDC_CLK_NS         64'd10
`define CCDC_FH_MILLIHZ     64'd15734263
`define CCDC_TOL_PCT        64'd3
`define CCDC_LINE_CYC      (64'd1000000000000 / (`CCDC_FH_MILLIHZ * `CCDC_CLK_NS))
`define CCDC_LINE_MIN_CYC  (`CCDC_LINE_CYC * (64'd100 - `CCDC_TOL_PCT) / 64'd100)
`define CCDC_LINE_MAX_CYC  (`CCDC_LINE_CYC * (64'd100 + `CCDC_TOL_PCT) / 64'd100)
`define CCDC_DOTS_PER_LINE  64'd768
`define CCDC_NS_TO_DOTS(ns) ((ns) * `CCDC_DOTS_PER_LINE * `CCDC_FH_MILLIHZ / 64'd1000000000000)
`define CCDC_BOX_DLY_NS     64'd13600
`define CCDC_BOX_W_NS       64'd45018
`define CCDC_CHAR_W_NS      64'd42370
`define CCDC_BOX_DLY_DOTS   `CCDC_NS_TO_DOTS(`CCDC_BOX_DLY_NS)
`define CCDC_BOX_W_DOTS     `CCDC_NS_TO_DOTS(`CCDC_BOX_W_NS)
`define CCDC_CHAR_W_DOTS    `CCDC_NS_TO_DOTS(`CCDC_CHAR_W_NS)
`define CCDC_RUNIN_NS       64'd10500
`define CCDC_RUNIN_TOL_NS   64'd500
`define CCDC_RUNIN_MIN_CYC ((`CCDC_RUNIN_NS - `CCDC_RUNIN_TOL_NS + `CCDC_CLK_NS - 1) / `CCDC_CLK_NS)
`define CCDC_RUNIN_MAX_CYC ((`CCDC_RUNIN_NS + `CCDC_RUNIN_TOL_NS) / `CCDC_CLK_NS)
`define CCDC_VS_MIN_CYC    ((`CCDC_LINE_CYC * 64'd25 + 64'd9) / 64'd10)
`define CCDC_SERR_MAX_CYC  (`CCDC_LINE_CYC / 64'd8)
`define CCDC_MRST_NS        64'd100
`define CCDC_MRST_CYC      ((`CCDC_MRST_NS + `CCDC_CLK_NS - 1) / `CCDC_CLK_NS)
`define CCDC_VS_DET_LINE    9'd6
`define CCDC_CAP_LINE       9'd21

`endif

// [rtl/ccdc_top.sv]
// Control and timing core of a line 21 caption decoder.
// Assumes pins arrive asynchronously; register port is on clk_sys.
// Operation
// - Style pin picks parallel or serial controls
// - Power pin: on/off, or serial frame enable
// - Channel pin: captions/text, or serial data
// - Language pin: language one/two, or clock
// - Active-high box keying over display area
// - Active-high luma and RGB character outputs
// - Box starts fixed delay after sync edge; here the delay is box_dly_q, writable
// - Either sync polarity, three percent line tolerance
// - Master reset low stops all circuits; here the register port and its settings keep running
// - Serial reset command equals master reset
// - Command reset clears display, keeps timing
// - Dot clock is 768 times line rate
// - Char video and box span their widths
// - Lock to long vertical sync, skip serrations
// - Expect run-in at nominal time after sync
// - Line 21 field one, extended data field two
// - Open-drain read bit, released on falls
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "ccdc_regs.svh"

module ccdc_top
  import ccdc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Device pins
  input  wire ccdc_pins_t  pins,
  output ccdc_video_t      video_q,
  output logic             sda_out_q,
  output logic             sda_oe_q,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata_q
);

  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v < hi);
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  ccdc_pins_t pins_s1_q;
  ccdc_pins_t pins_s2_q;
  ccdc_pins_t pins_d_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pins_s1_q <= '0;
      pins_s2_q <= '0;
      pins_d_q  <= '0;
    end else begin
      pins_s1_q <= pins;
      pins_s2_q <= pins_s1_q;
      pins_d_q  <= pins_s2_q;
    end
  end

  logic serial_mode;
  logic en_rise;
  logic en_fall;
  logic sck_rise;
  logic sck_fall;
  assign serial_mode = !pins_s2_q.interface_style_select;
  assign en_rise  = pins_s2_q.decoder_power_or_serial_enable
                    && !pins_d_q.decoder_power_or_serial_enable;
  assign en_fall  = !pins_s2_q.decoder_power_or_serial_enable
                    && pins_d_q.decoder_power_or_serial_enable;
  assign sck_rise = pins_s2_q.language_select_or_serial_clock
                    && !pins_d_q.language_select_or_serial_clock;
  assign sck_fall = !pins_s2_q.language_select_or_serial_clock
                    && pins_d_q.language_select_or_serial_clock;

  // ----------------------------------------------------------------------
  // Full reset
  // ----------------------------------------------------------------------
  logic [3:0] mrst_cnt_q;
  logic       ser_full_rst_q;
  logic       full_rst;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mrst_cnt_q <= 4'h0;
    end else if (pins_s2_q.master_reset_n) begin
      mrst_cnt_q <= 4'h0;
    end else if (mrst_cnt_q != 4'(`CCDC_MRST_CYC)) begin
      mrst_cnt_q <= mrst_cnt_q + 4'h1;
    end
  end

  // Pin held long enough, or serial command, stops everything except the register port
  assign full_rst = (mrst_cnt_q == 4'(`CCDC_MRST_CYC)) || ser_full_rst_q;

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  logic       eds_sel_q;
  logic [2:0] colour_q;
  logic [9:0] box_dly_q;
  logic       sw_cp_rst_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      eds_sel_q   <= 1'b0;
      colour_q    <= `CCDC_CTRL_RST;
      box_dly_q   <= 10'(`CCDC_BOX_DLY_DOTS);
      sw_cp_rst_q <= 1'b0;
    end else begin
      sw_cp_rst_q <= wr && (addr == `CCDC_OFF_CTRL) && wdata[`CCDC_CTRL_CPR_BIT];
      if (wr && (addr == `CCDC_OFF_CTRL)) begin
        eds_sel_q <= wdata[`CCDC_CTRL_EDS_BIT];
        colour_q  <= wdata[`CCDC_CTRL_RGB_LSB +: 3];
      end
      if (wr && (addr == `CCDC_OFF_BOX_DLY)) begin
        box_dly_q <= wdata[9:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Horizontal timing
  // ----------------------------------------------------------------------
  logic        hpol_q;
  logic [13:0] hi_len_q;
  logic [13:0] lo_len_q;
  logic [13:0] line_cnt_q;
  logic [13:0] line_len_q;
  logic        h_lock_q;
  logic        h_lead;

  // Pulse level is whichever phase is shorter
  assign h_lead = hpol_q ? (pins_s2_q.horizontal_timing_in && !pins_d_q.horizontal_timing_in)
                         : (!pins_s2_q.horizontal_timing_in && pins_d_q.horizontal_timing_in);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hpol_q     <= 1'b0;
      hi_len_q   <= 14'h0;
      lo_len_q   <= 14'h0;
      line_cnt_q <= 14'h0;
      line_len_q <= 14'(`CCDC_LINE_CYC);
      h_lock_q   <= 1'b0;
    end else if (full_rst) begin
      hpol_q     <= 1'b0;
      hi_len_q   <= 14'h0;
      lo_len_q   <= 14'h0;
      line_cnt_q <= 14'h0;
      line_len_q <= 14'(`CCDC_LINE_CYC);
      h_lock_q   <= 1'b0;
    end else begin
      if (pins_s2_q.horizontal_timing_in != pins_d_q.horizontal_timing_in) begin
        hpol_q <= pins_d_q.horizontal_timing_in ? (hi_len_q < lo_len_q)
                                                : (lo_len_q >= hi_len_q);
        // Clear the phase that starts, keep the one that just ended
        if (pins_d_q.horizontal_timing_in) begin
          lo_len_q <= 14'h0;
        end else begin
          hi_len_q <= 14'h0;
        end
      end else if (pins_s2_q.horizontal_timing_in && hi_len_q != 14'h3FFF) begin
        hi_len_q <= hi_len_q + 14'h1;
      end else if (!pins_s2_q.horizontal_timing_in && lo_len_q != 14'h3FFF) begin
        lo_len_q <= lo_len_q + 14'h1;
      end
      if (h_lead) begin
        line_cnt_q <= 14'h0;
        h_lock_q   <= in_range({2'b00, line_cnt_q}, 16'(`CCDC_LINE_MIN_CYC),
                               16'(`CCDC_LINE_MAX_CYC + 64'd1));
        if (in_range({2'b00, line_cnt_q}, 16'(`CCDC_LINE_MIN_CYC),
                     16'(`CCDC_LINE_MAX_CYC + 64'd1))) begin
          line_len_q <= line_cnt_q;
        end
      end else if (line_cnt_q != 14'h3FFF) begin
        line_cnt_q <= line_cnt_q + 14'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Dot clock, 768 ticks per measured line
  // ----------------------------------------------------------------------
  logic [13:0] dot_acc_q;
  logic [9:0]  dot_cnt_q;
  logic [13:0] acc_sum;
  assign acc_sum = dot_acc_q + 14'(`CCDC_DOTS_PER_LINE);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dot_acc_q <= 14'h0;
      dot_cnt_q <= 10'h0;
    end else if (full_rst || h_lead) begin
      dot_acc_q <= 14'h0;
      dot_cnt_q <= 10'h0;
    end else if (acc_sum >= line_len_q) begin
      dot_acc_q <= acc_sum - line_len_q;
      if (dot_cnt_q != 10'(`CCDC_DOTS_PER_LINE - 64'd1)) begin
        dot_cnt_q <= dot_cnt_q + 10'h1;
      end
    end else begin
      dot_acc_q <= acc_sum;
    end
  end

  // ----------------------------------------------------------------------
  // Vertical sync and line count
  // ----------------------------------------------------------------------
  logic [13:0] vs_len_q;
  logic [13:0] serr_q;
  logic [13:0] vs_pos_q;
  logic        vs_done_q;
  logic        field2_q;
  logic [8:0]  line_num_q;
  logic        csync;
  assign csync = pins_s2_q.composite_sync_in;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vs_len_q   <= 14'h0;
      serr_q     <= 14'h0;
      vs_pos_q   <= 14'h0;
      vs_done_q  <= 1'b0;
      field2_q   <= 1'b0;
      line_num_q <= 9'h0;
    end else if (full_rst) begin
      vs_len_q   <= 14'h0;
      serr_q     <= 14'h0;
      vs_pos_q   <= 14'h0;
      vs_done_q  <= 1'b0;
      field2_q   <= 1'b0;
      line_num_q <= 9'h0;
    end else begin
      if (csync) begin
        serr_q <= 14'h0;
        if (vs_len_q == 14'h0) begin
          vs_pos_q <= line_cnt_q;
        end
        if (vs_len_q != 14'h3FFF) begin
          vs_len_q <= vs_len_q + 14'h1;
        end
      end else if (serr_q < 14'(`CCDC_SERR_MAX_CYC)) begin
        serr_q <= serr_q + 14'h1;
        if (vs_len_q != 14'h0 && vs_len_q != 14'h3FFF) begin
          vs_len_q <= vs_len_q + 14'h1;
        end
      end else begin
        vs_len_q  <= 14'h0;
        vs_done_q <= 1'b0;
      end
      if (vs_len_q >= 14'(`CCDC_VS_MIN_CYC) && !vs_done_q) begin
        vs_done_q  <= 1'b1;
        field2_q   <= vs_pos_q >= (line_len_q >> 1);
        line_num_q <= `CCDC_VS_DET_LINE;
      end else if (h_lead && line_num_q != 9'h1FF) begin
        line_num_q <= line_num_q + 9'h1;
      end
    end
  end

  // Vertical lock stays from first detection until full reset
  logic v_lock_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      v_lock_q <= 1'b0;
    end else if (full_rst) begin
      v_lock_q <= 1'b0;
    end else if (vs_done_q) begin
      v_lock_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------------
  ccdc_ser_state_t ser_state_q;
  logic [8:0]      ser_shift_q;
  logic [8:0]      last_cmd_q;
  logic            ser_cp_rst_q;
  logic            ser_drive_q;
  logic            ser_power_q;
  logic            ser_caption_q;
  logic            ser_lang1_q;
  logic            disp_valid_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ser_state_q <= CCDC_SER_IDLE;
      ser_shift_q <= 9'h0;
    end else if (full_rst || !serial_mode) begin
      ser_state_q <= CCDC_SER_IDLE;
      ser_shift_q <= 9'h0;
    end else begin
      unique case (ser_state_q)
        CCDC_SER_IDLE: begin
          if (en_rise) begin
            ser_state_q <= CCDC_SER_SHIFT;
            ser_shift_q <= 9'h0;
          end
        end
        CCDC_SER_SHIFT: begin
          if (en_fall) begin
            ser_state_q <= CCDC_SER_EXEC;
          end else if (sck_rise) begin
            ser_shift_q <= {ser_shift_q[7:0], pins_s2_q.channel_type_or_serial_data};
          end
        end
        CCDC_SER_EXEC: begin
          ser_state_q <= CCDC_SER_IDLE;
        end
        default: begin
          ser_state_q <= CCDC_SER_IDLE;
        end
      endcase
    end
  end

  logic ser_exec;
  logic cmd_frame;
  assign ser_exec  = (ser_state_q == CCDC_SER_EXEC);
  assign cmd_frame = ser_exec && !ser_shift_q[8]; // Address bit low: command

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ser_full_rst_q <= 1'b0;
    end else begin
      ser_full_rst_q <= cmd_frame && (ser_shift_q[7:0] == `CCDC_CMD_FULL_RST);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_cmd_q    <= 9'h0;
      ser_cp_rst_q  <= 1'b0;
      ser_power_q   <= 1'b0;
      ser_caption_q <= 1'b0;
      ser_lang1_q   <= 1'b0;
    end else if (full_rst) begin
      last_cmd_q    <= 9'h0;
      ser_cp_rst_q  <= 1'b0;
      ser_power_q   <= 1'b0;
      ser_caption_q <= 1'b0;
      ser_lang1_q   <= 1'b0;
    end else begin
      ser_cp_rst_q <= cmd_frame && (ser_shift_q[7:0] == `CCDC_CMD_CP_RST);
      if (ser_exec) begin
        last_cmd_q <= ser_shift_q;
      end
      if (cmd_frame && ser_shift_q[7:3] == `CCDC_CMD_SET_PFX) begin
        ser_power_q   <= ser_shift_q[2];
        ser_caption_q <= ser_shift_q[1];
        ser_lang1_q   <= ser_shift_q[0];
      end
    end
  end

  // Open-drain read bit: pulls low only for a zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ser_drive_q <= 1'b0;
      sda_oe_q    <= 1'b0;
      sda_out_q   <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
      if (full_rst || !serial_mode || en_fall || sck_fall) begin
        ser_drive_q <= 1'b0;
        sda_oe_q    <= 1'b0;
      end else if (en_rise) begin
        ser_drive_q <= 1'b1;
        sda_oe_q    <= !disp_valid_q;
      end else begin
        sda_oe_q <= ser_drive_q && !disp_valid_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Mode selection and caption presence
  // ----------------------------------------------------------------------
  logic power_on;
  logic caption_sel;
  logic lang1_sel;
  logic runin_win;
  logic data_rise;
  assign power_on    = serial_mode ? ser_power_q
                                   : pins_s2_q.decoder_power_or_serial_enable;
  assign caption_sel = serial_mode ? ser_caption_q
                                   : pins_s2_q.channel_type_or_serial_data;
  assign lang1_sel   = serial_mode ? ser_lang1_q
                                   : pins_s2_q.language_select_or_serial_clock;
  assign runin_win = in_range({2'b00, line_cnt_q}, 16'(`CCDC_RUNIN_MIN_CYC),
                              16'(`CCDC_RUNIN_MAX_CYC + 64'd1));
  assign data_rise = pins_s2_q.line21_data_in && !pins_d_q.line21_data_in;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      disp_valid_q <= 1'b0;
    end else if (full_rst) begin
      disp_valid_q <= 1'b0;
    end else if (line_num_q == `CCDC_CAP_LINE && field2_q == eds_sel_q
                 && runin_win && data_rise && v_lock_q) begin
      disp_valid_q <= 1'b1;
    end else if (ser_cp_rst_q || sw_cp_rst_q) begin
      disp_valid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Keying and character video
  // ----------------------------------------------------------------------
  logic [15:0] box_lo;
  logic [15:0] char_lo;
  logic        show;
  assign box_lo  = {6'h00, box_dly_q};
  assign char_lo = box_lo + 16'((`CCDC_BOX_W_DOTS - `CCDC_CHAR_W_DOTS) / 64'd2);
  assign show    = power_on && disp_valid_q && h_lock_q && (line_num_q > `CCDC_CAP_LINE);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      video_q <= '0;
    end else if (full_rst) begin
      video_q <= '0;
    end else begin
      video_q.box <= show && in_range({6'h00, dot_cnt_q}, box_lo,
                                      box_lo + 16'(`CCDC_BOX_W_DOTS));
      video_q.char_luma_out <= show && in_range({6'h00, dot_cnt_q}, char_lo,
                                                char_lo + 16'(`CCDC_CHAR_W_DOTS));
      video_q.rgb <= (show && in_range({6'h00, dot_cnt_q}, char_lo,
                                       char_lo + 16'(`CCDC_CHAR_W_DOTS)))
                     ? colour_q : 3'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0;
    end else if (rd) begin
      unique case (addr)
        `CCDC_OFF_CTRL:     rdata_q <= {28'h0, colour_q, eds_sel_q};
        `CCDC_OFF_BOX_DLY:  rdata_q <= {22'h0, box_dly_q};
        `CCDC_OFF_STATUS:   rdata_q <= {24'h0, serial_mode, disp_valid_q, lang1_sel,
                                        caption_sel, power_on, field2_q, hpol_q, h_lock_q};
        `CCDC_OFF_LAST_CMD: rdata_q <= {23'h0, last_cmd_q};
        default:            rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

endmodule

// [tb/ccdc_host_model.sv]
// Host controller on the decoder control pins.
// Assumes the bench calls its tasks; data pin has a pull-up.
`timescale 1ns/1ps
module ccdc_host_model (
  // Clock and device answer
  input  wire logic clk_sys,
  input  wire logic sda_oe_q,
  // Control pins
  output logic      style,
  output logic      enable,
  output wire logic sda_line,
  output logic      sck,
  output logic      reset_n,
  output logic      read_bit_q
);
  logic data;

  // Wired data line, device only pulls low
  assign sda_line = data & ~sda_oe_q;

  initial begin
    style      = 1'b1;
    enable     = 1'b0;
    data       = 1'b1;
    sck        = 1'b0;
    reset_n    = 1'b1;
    read_bit_q = 1'b0;
  end

  task automatic set_pins(input logic [3:0] slcp);
    style  <= slcp[3];
    sck    <= slcp[2];
    data   <= slcp[1];
    enable <= slcp[0];
  endtask

  task automatic hold_reset(input int n);
    reset_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask

  task automatic send_frame(input logic [8:0] frame);
    enable <= 1'b1;
    #300;
    read_bit_q <= sda_line;
    for (int i = 8; i >= 0; i--) begin
      data <= frame[i];
      #62.5;
      sck <= 1'b1;
      #62.5;
      sck <= 1'b0;
    end
    #62.5;
    data   <= 1'b1;
    enable <= 1'b0;
    #300;
  endtask
endmodule

// [tb/ccdc_tb_top.sv]
// Self-checking bench of the caption decoder core.
// Assumes the host model and port checker are compiled first.
`timescale 1ns/1ps
`include "ccdc_regs.svh"
module ccdc_tb_top
  import ccdc_pkg::*;
;
  logic        clk_sys;
  logic        rst;
  ccdc_pins_t  pins;
  ccdc_video_t video_q;
  logic        sda_out_q, sda_oe_q, wr, rd, h_run, h_q;
  logic        style, enable, sda_line, sck, reset_n, read_bit_q;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata_q, v;
  logic [12:0] h_cnt_q;
  int          fail_count;
  int          comparisons;

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  // Line-rate sync pulses, high polarity
  always @(posedge clk_sys) begin
    h_cnt_q <= (rst || h_cnt_q == 13'h18D3) ? 13'h0000 : h_cnt_q + 13'h0001;
    h_q     <= h_run && (h_cnt_q < 13'h01D6);
  end

  assign pins = {style, enable, sda_line, sck, reset_n, h_q, h_q, 1'b0};

  ccdc_top u_ccdc_top (.clk_sys(clk_sys), .rst(rst), .pins(pins), .video_q(video_q),
    .sda_out_q(sda_out_q), .sda_oe_q(sda_oe_q), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q));
  ccdc_host_model u_ccdc_host_model (.clk_sys(clk_sys), .sda_oe_q(sda_oe_q), .style(style),
    .enable(enable), .sda_line(sda_line), .sck(sck), .reset_n(reset_n),
    .read_bit_q(read_bit_q));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata_q;
  endtask

  task automatic frame_then_status(input logic [8:0] f);
    u_ccdc_host_model.send_frame(f);
    repeat (10) @(posedge clk_sys);
    rd_reg(`CCDC_OFF_STATUS, v);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk_sys);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    {rst, wr, rd, h_run, addr, wdata} = {4'h8, 8'h00, 32'h0};
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd_reg(`CCDC_OFF_CTRL, v);
    check(v, 32'h0000000E);
    rd_reg(`CCDC_OFF_BOX_DLY, v);
    check(v, 32'h000000A4);
    wr_reg(`CCDC_OFF_BOX_DLY, 32'hFFFFF3A0);
    rd_reg(`CCDC_OFF_BOX_DLY, v);
    check(v, 32'h000003A0);
    wr_reg(`CCDC_OFF_BOX_DLY, 32'h000000A4);
    wr_reg(`CCDC_OFF_LAST_CMD, 32'h000001FF);
    rd_reg(`CCDC_OFF_LAST_CMD, v);
    check(v, 32'h00000000);
    rd_reg(8'h10, v);
    check(v, 32'h00000000);
    wr_reg(`CCDC_OFF_CTRL, 32'h0000000A);
    for (int i = 0; i < 8; i++) begin
      u_ccdc_host_model.set_pins({1'b1, i[2:0]});
      repeat (5) @(posedge clk_sys);
      rd_reg(`CCDC_OFF_STATUS, v);
      check(v & 32'hB8, {26'h0, i[2:0], 3'h0});
    end
    u_ccdc_host_model.set_pins(4'h9);
    h_run <= 1'b1;
    repeat (25424) @(posedge clk_sys);
    rd_reg(`CCDC_OFF_STATUS, v);
    check(v & 32'h3, 32'h3);
    u_ccdc_host_model.hold_reset(5);
    repeat (10) @(posedge clk_sys);
    rd_reg(`CCDC_OFF_STATUS, v);
    check(v & 32'h1, 32'h1);
    u_ccdc_host_model.hold_reset(20);
    rd_reg(`CCDC_OFF_STATUS, v);
    check(v & 32'h1, 32'h0);
    rd_reg(`CCDC_OFF_CTRL, v);
    check(v, 32'h0000000A);
    u_ccdc_host_model.set_pins(4'h2);
    repeat (25424) @(posedge clk_sys);
    frame_then_status(9'h087);
    check(v & 32'hF9, 32'hB9);
    rd_reg(`CCDC_OFF_LAST_CMD, v);
    check(v, 32'h00000087);
    frame_then_status(9'h105);
    check({31'h0, read_bit_q}, 32'h0);
    check(v & 32'hF9, 32'hB9);
    frame_then_status(9'h085);
    check(v & 32'hF9, 32'hA9);
    frame_then_status(9'h002);
    check(v & 32'hC1, 32'h81);
    frame_then_status(9'h001);
    check(v & 32'hBD, 32'h80);
    rd_reg(`CCDC_OFF_CTRL, v);
    check(v, 32'h0000000A);
    tally_and_finish();
  end
endmodule

// [tb/ccdc_top_monitor.sv]
// Port checker of the caption decoder core.
// Assumes binding onto ccdc_top; sees its ports only.
`timescale 1ns/1ps
module ccdc_top_monitor
  import ccdc_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Watched ports
  input wire ccdc_pins_t  pins,
  input wire ccdc_video_t video_q,
  input wire logic        sda_out_q,
  input wire logic        sda_oe_q,
  input wire logic        rd,
  input wire logic [31:0] rdata_q
);
  // --------------------
  // Run-length counters
  // --------------------
  logic [4:0]  low_cnt_q;
  logic [4:0]  off_cnt_q;
  logic [12:0] box_cnt_q;
  logic        off_now;

  assign off_now = pins.interface_style_select && !pins.decoder_power_or_serial_enable;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_cnt_q <= 5'h00;
      off_cnt_q <= 5'h00;
      box_cnt_q <= 13'h0000;
    end else begin
      low_cnt_q <= pins.master_reset_n ? 5'h00 : low_cnt_q + {4'h0, low_cnt_q != 5'h1F};
      off_cnt_q <= off_now ? off_cnt_q + {4'h0, off_cnt_q != 5'h1F} : 5'h00;
      box_cnt_q <= video_q.box ? box_cnt_q + {12'h000, box_cnt_q != 13'h1FFF} : 13'h0000;
    end
  end

  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata_q == 32'h0)
    else $error("read data not zero outside the answer cycle");
  a_sda_pull_only: assert property (sda_out_q == 1'b0)
    else $error("data pin driven high");
  a_oe_enable_fall: assert property (
    $fell(pins.decoder_power_or_serial_enable) && !pins.interface_style_select
    |-> ##6 !sda_oe_q) else $error("data pin held after enable fall");
  a_oe_clock_fall: assert property (
    $fell(pins.language_select_or_serial_clock) && !pins.interface_style_select
    |-> ##6 !sda_oe_q) else $error("data pin held after clock fall");
  a_reset_dark: assert property (low_cnt_q >= 5'h10 |-> video_q == 5'h00)
    else $error("video active during master reset");
  a_power_dark: assert property (off_cnt_q >= 5'h08 |-> video_q == 5'h00)
    else $error("video active while powered off");
  a_luma_in_box: assert property (video_q.char_luma_out |-> video_q.box)
    else $error("luma outside box");
  a_rgb_in_box: assert property (video_q.rgb != 3'h0 |-> video_q.box)
    else $error("colour outside box");
  a_box_bounded: assert property (box_cnt_q <= 13'h11A8)
    else $error("box wider than one row");
endmodule

bind ccdc_top ccdc_top_monitor u_ccdc_top_monitor (
  .clk_sys   (clk_sys),
  .rst       (rst),
  .pins      (pins),
  .video_q   (video_q),
  .sda_out_q (sda_out_q),
  .sda_oe_q  (sda_oe_q),
  .rd        (rd),
  .rdata_q   (rdata_q)
);
